//--- rtl/phc_holdover_ctl.sv
// Lock indication, lock pin drive and holdover control for the PLL.
// Overview of operation
// - Current source mode sources current while locked.
// - Current source mode shorts pin when unlocked.
// - Comparator disabled means pin sensed high.
// - Comparator result selectable on monitor/status pins.
// - Enable-on-lock outputs follow charged lock indication.
// - Holdover enable gates both holdover modes.
// - External bit selects manual or automatic holdover.
// - Synchronised sync falling edge enters manual holdover at once.
// - Release only at a reference comparator edge; manual release also needs sync high.
// - Feedback B counter reset at release.
// - Automatic holdover enters when sensed lock lost.
// - Automatic holdover reads lock pin level.
// - Holdover persists while no reference arrives.
// - Re-entry blocked until sensed lock returns high.
// - Holdover follows currently selected reference edges.
// - Two-bit field sets cycles; zero means five.
// - Disable bit turns digital lock off.
// - Window bit selects range; zero is high.
// - Reference select: auto switch, preference, buffers.
// - Lock after count; unlock on single wide miss.
module phc_holdover_ctl #(
   parameter int unsigned CHARGE_CYCLES = phc_pkg::CHARGE_CYCLES_DEF
) (
   input  wire logic                         clk_in,
   input  wire logic                         rst_in,
   input  wire logic [phc_pkg::ADDR_W-1:0]   addr_in,
   input  wire logic [phc_pkg::DATA_W-1:0]   wdata_in,
   input  wire logic                         wr_in,
   input  wire logic                         rd_in,
   output logic      [phc_pkg::DATA_W-1:0]   rdata_out,
   input  wire phc_pkg::phc_pd_s             pd_in,
   input  wire logic                         sync_n_in,
   input  wire logic                         lock_detect_pin_in,
   output logic                              lock_detect_pin_out,
   output logic                              lock_detect_pin_oe_out,
   output logic                              lock_detect_pin_src_out,
   output logic                              reference_monitor_pin_out,
   output logic                              status_pin_out,
   output logic      [phc_pkg::N_OUTS-1:0]   clk_out_en_out,
   output logic                              cp_hiz_out,
   output logic                              b_reset_out,
   output logic                              ref_auto_switch_out,
   output logic                              ref_prefer_secondary_out,
   output logic      [1:0]                   ref_buf_en_out,
   output logic                              window_low_range_out,
   output logic                              digital_lock_indication_out,
   output logic                              charged_lock_indication_out
);
   import phc_pkg::*;

   localparam logic [15:0] CHG_MAX = 16'(CHARGE_CYCLES);

   typedef struct packed {
      logic [7:0]  r_status;
      logic [7:0]  r_lock;
      logic [7:0]  r_ldpin;
      logic [7:0]  r_reference_monitor_pin;
      logic [7:0]  r_refsel;
      logic [7:0]  r_hold;
      logic [7:0]  r_onlock0;
      logic [7:0]  r_onlock1;
      logic [2:0]  sync_ff;
      logic        sync_lvl;
      logic [2:0]  ldp_ff;
      logic        ldp_lvl;
      logic [7:0]  lock_cnt;
      logic        digital_lock_indication;
      logic [15:0] chg_cnt;
      phc_ho_e     ho;
      logic [7:0]  rdata;
   } phc_state_s;

   phc_state_s st_q;
   phc_state_s st_d;

   // Cycles in window needed to declare lock.
   function automatic logic [7:0] lock_need(input logic [1:0] sel);
      logic [7:0] n;
      n = LOCK_CYC_0;
      case (sel)
         2'b01: n = LOCK_CYC_1;
         2'b10: n = LOCK_CYC_2;
         2'b11: n = LOCK_CYC_3;
         default: n = LOCK_CYC_0;
      endcase
      return n;
   endfunction

   logic hold_en;
   logic manual;
   logic cmp_en;
   logic sensed;
   logic sync_fall;
   logic enter;
   logic release_now;
   logic charged;
   logic [7:0] need;

   logic lock_dis;
   logic csrc_mode;
   logic ref_release;
   logic cmp_out;
   logic [N_OUTS-1:0] onlock_mask;

   assign hold_en = st_q.r_hold[HO_EN];
   assign manual  = st_q.r_hold[HO_EXT];
   assign cmp_en  = st_q.r_hold[HO_CMP_EN];
   // A disabled comparator reads as a permanently locked pin.
   assign sensed  = cmp_en ? st_q.ldp_lvl : 1'b1;
   assign charged = (st_q.chg_cnt == CHG_MAX);
   assign need    = lock_need(st_q.r_lock[LD_CNT_LO +: 2]);
   assign lock_dis = st_q.r_lock[LD_DIS];

   // Current source mode needs the full six-bit code; every other code is push-pull.
   assign csrc_mode = (st_q.r_ldpin[5:0] == LDP_CSRC);

   // Manual release also waits for the synchronised sync level to be back high,
   // so a reference edge while the pin is still low keeps the pump parked.
   assign ref_release = pd_in.ref_edge & (~manual | st_q.sync_lvl);

   // The comparator result on a pin reads low while the comparator is switched off.
   assign cmp_out = cmp_en & st_q.ldp_lvl;

   // Only the low nibble of the second enable-on-lock register maps to an output.
   assign onlock_mask = {st_q.r_onlock1[3:0], st_q.r_onlock0};

   always_comb begin
      st_d        = st_q;
      sync_fall   = 1'b0;
      enter       = 1'b0;
      release_now = 1'b0;

      // Register writes; the state word is read-only, so a write to it falls through.
      if (wr_in) begin
         if (addr_in == A_STATUS_CTL) begin
            st_d.r_status = wdata_in;
         end else if (addr_in == A_LOCK_DET) begin
            st_d.r_lock = wdata_in;
         end else if (addr_in == A_LDPIN_CTL) begin
            st_d.r_ldpin = wdata_in;
         end else if (addr_in == A_REFERENCE_MONITOR_PIN_CTL) begin
            st_d.r_reference_monitor_pin = wdata_in;
         end else if (addr_in == A_REF_SEL) begin
            st_d.r_refsel = wdata_in;
         end else if (addr_in == A_HOLDOVER) begin
            st_d.r_hold = wdata_in;
         end else if (addr_in == A_OUT_ONLOCK0) begin
            st_d.r_onlock0 = wdata_in;
         end else if (addr_in == A_OUT_ONLOCK1) begin
            st_d.r_onlock1 = wdata_in;
         end
      end

      // Register reads; unmapped addresses read as zero.
      // Read data arrive the cycle after the read strobe, stand for one cycle and then fall back to zero.
      st_d.rdata = RST_VAL;
      if (rd_in) begin
         if (addr_in == A_STATUS_CTL) begin
            st_d.rdata = st_q.r_status;
         end else if (addr_in == A_LOCK_DET) begin
            st_d.rdata = st_q.r_lock;
         end else if (addr_in == A_LDPIN_CTL) begin
            st_d.rdata = st_q.r_ldpin;
         end else if (addr_in == A_REFERENCE_MONITOR_PIN_CTL) begin
            st_d.rdata = st_q.r_reference_monitor_pin;
         end else if (addr_in == A_REF_SEL) begin
            st_d.rdata = st_q.r_refsel;
         end else if (addr_in == A_HOLDOVER) begin
            st_d.rdata = st_q.r_hold;
         end else if (addr_in == A_OUT_ONLOCK0) begin
            st_d.rdata = st_q.r_onlock0;
         end else if (addr_in == A_OUT_ONLOCK1) begin
            st_d.rdata = st_q.r_onlock1;
         end else if (addr_in == A_STATE) begin
            st_d.rdata = {2'b00,
                          st_q.ho == HO_REARM,
                          st_q.ho == HO_HOLD,
                          st_q.sync_lvl,
                          sensed,
                          charged,
                          st_q.digital_lock_indication};
         end
      end

      // Pin synchronisers: a level counts once stages two and three agree.
      // The first stage may go metastable, so it is never compared directly.
      st_d.sync_ff = {st_q.sync_ff[1:0], sync_n_in};
      if (st_q.sync_ff[1] == st_q.sync_ff[2]) begin
         st_d.sync_lvl = st_q.sync_ff[2];
      end
      st_d.ldp_ff = {st_q.ldp_ff[1:0], lock_detect_pin_in};
      if (st_q.ldp_ff[1] == st_q.ldp_ff[2]) begin
         st_d.ldp_lvl = st_q.ldp_ff[2];
      end
      sync_fall = st_q.sync_lvl & ~st_d.sync_lvl;

      // Digital lock detect.
      // Only consecutive in-window cycles count; a miss short of the unlock threshold restarts.
      if (lock_dis) begin
         st_d.digital_lock_indication      = 1'b0;
         st_d.lock_cnt = 8'h00;
      end else if (pd_in.pd_cycle) begin
         if (pd_in.over_unlock) begin
            st_d.digital_lock_indication      = 1'b0;
            st_d.lock_cnt = 8'h00;
         end else if (pd_in.in_window) begin
            if (!st_q.digital_lock_indication) begin
               st_d.lock_cnt = st_q.lock_cnt + 8'h01;
               if (st_d.lock_cnt >= need) begin
                  st_d.digital_lock_indication      = 1'b1;
                  st_d.lock_cnt = 8'h00;
               end
            end
         end else if (!st_q.digital_lock_indication) begin
            st_d.lock_cnt = 8'h00;
         end
      end

      // Capacitor charge: any lock drop discharges at once.
      if (!st_q.digital_lock_indication) begin
         st_d.chg_cnt = 16'h0000;
      end else if (!charged) begin
         st_d.chg_cnt = st_q.chg_cnt + 16'h0001;
      end

      // Holdover sequencing.
      case (st_q.ho)
         HO_IDLE: begin
            if (manual) begin
               enter = sync_fall;
            end else begin
               // Entry looks at the sensed pin level only, whatever drives the pin.
               enter = ~sensed;
            end
            if (enter) begin
               st_d.ho = HO_HOLD;
            end
         end
         HO_HOLD: begin
            // Without a reference edge the pump stays parked.
            if (ref_release) begin
               release_now = 1'b1;
               st_d.ho     = manual ? HO_IDLE : HO_REARM;
            end
         end
         HO_REARM: begin
            // Chatter on the lock pin cannot retrigger until it reads high.
            if (manual || sensed) begin
               st_d.ho = HO_IDLE;
            end
         end
         default: begin
            st_d.ho = HO_IDLE;
         end
      endcase

      // Clearing the enable returns to idle at once, even in the middle of a hold.
      if (!hold_en) begin
         st_d.ho     = HO_IDLE;
         enter       = 1'b0;
         release_now = 1'b0;
      end
   end

   // Synchronisers reset to the idle level of their pins, so no false edge follows reset.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q.r_status  <= RST_VAL;
         st_q.r_lock    <= RST_VAL;
         st_q.r_ldpin   <= RST_VAL;
         st_q.r_reference_monitor_pin  <= RST_VAL;
         st_q.r_refsel  <= RST_VAL;
         st_q.r_hold    <= RST_VAL;
         st_q.r_onlock0 <= RST_VAL;
         st_q.r_onlock1 <= RST_VAL;
         st_q.sync_ff   <= 3'h7;
         st_q.sync_lvl  <= 1'b1;
         st_q.ldp_ff    <= 3'h0;
         st_q.ldp_lvl   <= 1'b0;
         st_q.lock_cnt  <= 8'h00;
         st_q.digital_lock_indication       <= 1'b0;
         st_q.chg_cnt   <= 16'h0000;
         st_q.ho        <= HO_IDLE;
         st_q.rdata     <= RST_VAL;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata_out = st_q.rdata;

   // Holdover parks the pump on the entering cycle, not one later, and frees it in the
   // cycle of the releasing reference edge, the same cycle that resets the feedback counter.
   assign cp_hiz_out  = hold_en & (((st_q.ho == HO_HOLD) & ~release_now) | enter);
   assign b_reset_out = release_now;

   // Lock pin drive.
   always_comb begin
      if (csrc_mode) begin
         lock_detect_pin_src_out = st_q.digital_lock_indication;
         lock_detect_pin_oe_out  = ~st_q.digital_lock_indication;
         lock_detect_pin_out     = 1'b0;
      end else begin
         lock_detect_pin_src_out = 1'b0;
         lock_detect_pin_oe_out  = 1'b1;
         lock_detect_pin_out     = st_q.digital_lock_indication;
      end
   end

   // Monitor and status pin selection.
   always_comb begin
      reference_monitor_pin_out = 1'b0;
      if (st_q.r_reference_monitor_pin[4:0] == REFERENCE_MONITOR_PIN_LDCMP) begin
         reference_monitor_pin_out = cmp_out;
      end else if (st_q.r_reference_monitor_pin[4:0] == REFERENCE_MONITOR_PIN_DLD) begin
         reference_monitor_pin_out = st_q.digital_lock_indication;
      end
      status_pin_out = 1'b0;
      if (st_q.r_status[7:2] == STATUS_LDCMP) begin
         status_pin_out = cmp_out;
      end else if (st_q.r_status[7:2] == STATUS_DLD) begin
         status_pin_out = st_q.digital_lock_indication;
      end
   end

   // Gated outputs switch with the charged indication itself, with no extra stage.
   assign clk_out_en_out = ~onlock_mask | {N_OUTS{charged}};

   // Reference selection fields go straight out to the switchover logic.
   assign ref_auto_switch_out         = st_q.r_refsel[RS_AUTO];
   assign ref_prefer_secondary_out    = st_q.r_refsel[RS_PREF];
   assign ref_buf_en_out              = st_q.r_refsel[RS_BUF_LO +: 2];
   assign window_low_range_out        = st_q.r_lock[LD_WIN];
   assign digital_lock_indication_out = st_q.digital_lock_indication;
   assign charged_lock_indication_out = charged;

endmodule // phc_holdover_ctl

//--- rtl/phc_pkg.sv
// Package with register map, field positions and types for the PLL holdover control block.
package phc_pkg;

   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned N_OUTS = 12;

   localparam logic [9:0] A_STATUS_CTL  = 10'h017;
   localparam logic [9:0] A_LOCK_DET    = 10'h018;
   localparam logic [9:0] A_LDPIN_CTL   = 10'h01A;
   localparam logic [9:0] A_REFERENCE_MONITOR_PIN_CTL  = 10'h01B;
   localparam logic [9:0] A_REF_SEL     = 10'h01C;
   localparam logic [9:0] A_HOLDOVER    = 10'h01D;
   localparam logic [9:0] A_OUT_ONLOCK0 = 10'h0FC;
   localparam logic [9:0] A_OUT_ONLOCK1 = 10'h0FD;
   localparam logic [9:0] A_STATE       = 10'h0FE;

   localparam logic [7:0] RST_VAL = 8'h00;

   localparam int unsigned LD_CNT_LO = 5;
   localparam int unsigned LD_WIN    = 4;
   localparam int unsigned LD_DIS    = 3;
   localparam int unsigned RS_AUTO   = 4;
   localparam int unsigned RS_PREF   = 3;
   localparam int unsigned RS_BUF_LO = 1;
   localparam int unsigned HO_CMP_EN = 3;
   localparam int unsigned HO_EXT    = 1;
   localparam int unsigned HO_EN     = 0;

   localparam logic [5:0] LDP_CSRC      = 6'h04;
   localparam logic [4:0] REFERENCE_MONITOR_PIN_DLD    = 5'h01;
   localparam logic [4:0] REFERENCE_MONITOR_PIN_LDCMP  = 5'h02;
   localparam logic [5:0] STATUS_DLD    = 6'h01;
   localparam logic [5:0] STATUS_LDCMP  = 6'h02;

   localparam logic [7:0] LOCK_CYC_0 = 8'h05;
   localparam logic [7:0] LOCK_CYC_1 = 8'h10;
   localparam logic [7:0] LOCK_CYC_2 = 8'h40;
   localparam logic [7:0] LOCK_CYC_3 = 8'hFF;

   localparam int unsigned CHARGE_CYCLES_DEF = 1000;

   typedef enum logic [1:0] {
      HO_IDLE  = 2'b00,
      HO_HOLD  = 2'b01,
      HO_REARM = 2'b10
   } phc_ho_e;

   typedef struct packed {
      logic       pd_cycle;
      logic       in_window;
      logic       over_unlock;
      logic       ref_edge;
   } phc_pd_s;

endpackage : phc_pkg

//--- tb/phc_cap_model.sv
// Board-side model of the lock pin with its charging capacitor and pin level.
module phc_cap_model (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic oe_in,
   input  wire logic out_in,
   input  wire logic src_in,
   output logic      level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Charging cycles until the pin crosses the trip level; the value is arbitrary.
   localparam int CAP_CYC = 6;
   int chg;
   // A driven low pin drains the capacitor at once, so any lock drop restarts the delay.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in || (oe_in && !out_in)) begin
         chg <= 0;
      end else if (src_in && chg < CAP_CYC) begin
         chg <= chg + 1;
      end
   end
   assign level_out = oe_in ? out_in : (chg >= CAP_CYC);
endmodule // phc_cap_model

//--- tb/phc_holdover_ctl_chk.sv
// Checker of port relations for the PLL holdover control block.
module phc_holdover_ctl_chk (
   input wire logic                        clk_in,
   input wire logic                        rst_in,
   input wire logic                        rd_in,
   input wire logic                        wr_in,
   input wire logic [phc_pkg::DATA_W-1:0]  rdata_out,
   input wire phc_pkg::phc_pd_s            pd_in,
   input wire logic                        sync_n_in,
   input wire logic                        lock_detect_pin_in,
   input wire logic                        lock_detect_pin_out,
   input wire logic                        lock_detect_pin_oe_out,
   input wire logic                        lock_detect_pin_src_out,
   input wire logic [phc_pkg::N_OUTS-1:0]  clk_out_en_out,
   input wire logic                        cp_hiz_out,
   input wire logic                        b_reset_out,
   input wire logic                        digital_lock_indication_out,
   input wire logic                        charged_lock_indication_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero outside the answer cycle");
   chk_src_locked: assert property (lock_detect_pin_src_out |-> !lock_detect_pin_oe_out && digital_lock_indication_out)
      else $error("current source active without lock");
   chk_pin_short: assert property (lock_detect_pin_oe_out |-> lock_detect_pin_out == digital_lock_indication_out)
      else $error("driven lock pin differs from lock indication");
   chk_charge_clear: assert property (!digital_lock_indication_out |=> !charged_lock_indication_out)
      else $error("charged indication survived a lock drop");
   chk_out_en_lock: assert property (charged_lock_indication_out |-> &clk_out_en_out)
      else $error("output held off while charged lock is high");
   chk_hiz_cause: assert property ($rose(cp_hiz_out) |-> !$past(sync_n_in, 3) || !$past(sync_n_in, 4)
      || !$past(lock_detect_pin_in, 3) || !$past(lock_detect_pin_in, 4))
      else $error("charge pump went high impedance without cause");
   chk_hiz_release: assert property ($fell(cp_hiz_out) |-> pd_in.ref_edge || $past(wr_in))
      else $error("charge pump left high impedance without reference edge");
   chk_breset_cause: assert property (b_reset_out |-> pd_in.ref_edge && !cp_hiz_out && $past(cp_hiz_out))
      else $error("counter reset outside a release");
   chk_breset_pulse: assert property (b_reset_out |=> !b_reset_out)
      else $error("counter reset longer than one cycle");
endmodule // phc_holdover_ctl_chk
bind phc_holdover_ctl phc_holdover_ctl_chk phc_holdover_ctl_chk_i (.clk_in, .rst_in, .rd_in, .wr_in, .rdata_out,
   .pd_in, .sync_n_in, .lock_detect_pin_in, .lock_detect_pin_out, .lock_detect_pin_oe_out,
   .lock_detect_pin_src_out, .clk_out_en_out, .cp_hiz_out, .b_reset_out, .digital_lock_indication_out,
   .charged_lock_indication_out);

//--- tb/tb_phc_holdover_ctl.sv
// Self-checking testbench of the PLL holdover control block.
module tb_phc_holdover_ctl import phc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CHG = 8;
   logic              clk_in = 1'b0;
   logic              rst_in = 1'b1;
   logic              wr_in = 1'b0;
   logic              rd_in = 1'b0;
   logic              sync_n_in = 1'b1;
   logic [ADDR_W-1:0] addr_in = '0;
   logic [DATA_W-1:0] wdata_in = '0;
   phc_pd_s           pd_in = '0;
   wire               lock_detect_pin_in;
   logic [DATA_W-1:0] rdata_out;
   logic [N_OUTS-1:0] clk_out_en_out;
   logic [1:0]        ref_buf_en_out;
   logic              lock_detect_pin_out, lock_detect_pin_oe_out, lock_detect_pin_src_out;
   logic              reference_monitor_pin_out, status_pin_out, cp_hiz_out, b_reset_out;
   logic              ref_auto_switch_out, ref_prefer_secondary_out, window_low_range_out;
   logic              digital_lock_indication_out, charged_lock_indication_out;
   int                miscompares = 0;
   int                checks = 0;
   int                cyc = 0;
   int                need [4] = '{5, 16, 64, 255};
   phc_holdover_ctl #(.CHARGE_CYCLES(CHG)) phc_holdover_ctl_i (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in,
      .rd_in, .rdata_out, .pd_in, .sync_n_in, .lock_detect_pin_in, .lock_detect_pin_out, .lock_detect_pin_oe_out,
      .lock_detect_pin_src_out, .reference_monitor_pin_out, .status_pin_out, .clk_out_en_out, .cp_hiz_out,
      .b_reset_out, .ref_auto_switch_out, .ref_prefer_secondary_out, .ref_buf_en_out, .window_low_range_out,
      .digital_lock_indication_out, .charged_lock_indication_out);
   phc_cap_model phc_cap_model_i (.clk_in, .rst_in, .oe_in(lock_detect_pin_oe_out),
      .out_in(lock_detect_pin_out), .src_in(lock_detect_pin_src_out), .level_out(lock_detect_pin_in));
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [11:0] g, input logic [11:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(negedge clk_in);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      cmp(rdata_out, e);
   endtask
   task automatic pc(input int n, input logic w, input logic o);
      repeat (n) begin
         @(posedge clk_in);
         pd_in <= '{1'b1, w, o, 1'b0};
      end
      @(posedge clk_in);
      pd_in <= '0;
      @(negedge clk_in);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   // Pulses one reference edge and checks whether it releases the charge pump.
   task automatic re(input logic rel);
      @(posedge clk_in);
      pd_in.ref_edge <= 1'b1;
      @(negedge clk_in);
      cmp(b_reset_out, rel);
      cmp(cp_hiz_out, !rel);
      @(posedge clk_in);
      pd_in.ref_edge <= 1'b0;
   endtask
   task automatic sync(input logic v);
      @(posedge clk_in);
      sync_n_in <= v;
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(A_HOLDOVER, 8'h00);
      wr(A_REF_SEL, 8'h1E);
      wr(10'h0FF, 8'hAA);
      rd(10'h0FF, 8'h00);
      rd(A_REF_SEL, 8'h1E);
      cmp({ref_auto_switch_out, ref_prefer_secondary_out, ref_buf_en_out}, 12'h00F);
      wr(A_LOCK_DET, 8'h10);
      cmp(window_low_range_out, 1'b1);
      $display("test registers done");
      for (int c = 0; c < 4; c++) begin
         wr(A_LOCK_DET, 8'(c << 5));
         pc(need[c] - 1, 1'b1, 1'b0);
         cmp(digital_lock_indication_out, 1'b0);
         pc(1, 1'b1, 1'b0);
         cmp(digital_lock_indication_out, 1'b1);
         pc(1, 1'b0, 1'b1);
         cmp(digital_lock_indication_out, 1'b0);
      end
      cmp(window_low_range_out, 1'b0);
      pc(3, 1'b1, 1'b0);
      pc(1, 1'b0, 1'b0);
      pc(4, 1'b1, 1'b0);
      cmp(digital_lock_indication_out, 1'b0);
      wr(A_LOCK_DET, 8'h08);
      pc(5, 1'b1, 1'b0);
      cmp(digital_lock_indication_out, 1'b0);
      wr(A_LOCK_DET, 8'h00);
      $display("test lock count done");
      wr(A_LDPIN_CTL, 8'(LDP_CSRC));
      wr(A_HOLDOVER, 8'h08);
      wr(A_REFERENCE_MONITOR_PIN_CTL, 8'h01);
      wr(A_STATUS_CTL, 8'h08);
      wr(A_OUT_ONLOCK0, 8'h01);
      wr(A_OUT_ONLOCK1, 8'h08);
      cmp(clk_out_en_out, 12'h7FE);
      pc(5, 1'b1, 1'b0);
      cmp({lock_detect_pin_src_out, lock_detect_pin_oe_out, reference_monitor_pin_out, status_pin_out}, 12'h00A);
      wt(CHG - 3);
      cmp(charged_lock_indication_out, 1'b0);
      wt(15);
      cmp(clk_out_en_out, 12'hFFF);
      cmp(status_pin_out, 1'b1);
      rd(A_STATE, 8'h0F);
      wr(A_REFERENCE_MONITOR_PIN_CTL, 8'h02);
      wr(A_STATUS_CTL, 8'h04);
      cmp({reference_monitor_pin_out, status_pin_out}, 12'h003);
      wr(A_HOLDOVER, 8'h09);
      pc(1, 1'b0, 1'b1);
      cmp({lock_detect_pin_src_out, lock_detect_pin_oe_out, lock_detect_pin_out}, 12'h002);
      wt(6);
      cmp(cp_hiz_out, 1'b1);
      wt(30);
      cmp(cp_hiz_out, 1'b1);
      re(1'b1);
      wt(10);
      cmp(cp_hiz_out, 1'b0);
      wr(A_HOLDOVER, 8'h01);
      wt(6);
      cmp(cp_hiz_out, 1'b0);
      $display("test automatic holdover done");
      // Channel dividers are taken to ignore the sync pin from here on.
      wr(A_HOLDOVER, 8'h0B);
      wt(6);
      cmp(cp_hiz_out, 1'b0);
      sync(1'b0);
      wt(5);
      cmp(cp_hiz_out, 1'b1);
      re(1'b0);
      sync(1'b1);
      wt(6);
      cmp(cp_hiz_out, 1'b1);
      re(1'b1);
      wr(A_HOLDOVER, 8'h0A);
      sync(1'b0);
      wt(6);
      cmp(cp_hiz_out, 1'b0);
      wr(A_HOLDOVER, 8'h0B);
      wt(4);
      cmp(cp_hiz_out, 1'b0);
      sync(1'b1);
      $display("test manual holdover done");
      close_out();
   end
endmodule // tb_phc_holdover_ctl
